// ### src/mmd_pkg.sv
/*
 * Package for the memory map decoder: address widths, map boundaries,
 * fixed program-memory locations, region codes and access carriers.
 * Assumes byte-wide data and a single system clock.
 */
package mmd_pkg;

	localparam int RF_AW = 12;
	localparam int PM_AW = 16;
	localparam int DW    = 8;

	// Register file map
	localparam logic [11:0] RF_RAM_BASE  = 12'h000;
	localparam logic [11:0] RF_CTRL_BASE = 12'hf00;
	localparam logic [11:0] RF_CTRL_LAST = 12'hfff;
	localparam int          RF_SIZE      = 4096;
	localparam int          RF_CTRL_SIZE = 256;
	localparam int          RAM_MIN      = 2048;
	localparam int          RAM_MAX      = 4096;

	// Program memory map
	localparam int          PM_SIZE      = 65536;
	localparam int          FLASH_MIN    = 16384;
	localparam int          FLASH_MAX    = 65536;
	localparam logic [15:0] PM_OPTION    = 16'h0000;
	localparam logic [15:0] PM_RESET_VEC = 16'h0002;
	localparam logic [15:0] PM_WDOG_VEC  = 16'h0004;
	localparam logic [15:0] PM_TRAP_VEC  = 16'h0006;
	localparam logic [15:0] PM_IRQ_VEC   = 16'h0008;
	localparam logic [15:0] PM_IRQ_LAST  = 16'h0037;
	localparam logic [15:0] PM_CODE_BASE = 16'h0038;

	// Fill values
	localparam logic [7:0]  PM_BLANK     = 8'hff;
	localparam logic [7:0]  RF_UNDEF     = 8'h00;

	typedef enum logic [1:0] {
		RF_REG_RAM  = 2'b00,
		RF_REG_HOLE = 2'b01,
		RF_REG_CTRL = 2'b10
	} mmd_rf_region_e;

	typedef enum logic [2:0] {
		PM_FN_OPTION = 3'b000,
		PM_FN_RESET  = 3'b001,
		PM_FN_WDOG   = 3'b010,
		PM_FN_TRAP   = 3'b011,
		PM_FN_IRQ    = 3'b100,
		PM_FN_CODE   = 3'b101,
		PM_FN_NONE   = 3'b110
	} mmd_pm_func_e;

	typedef struct packed {
		logic             rd;
		logic             wr;
		logic [11:0]      addr;
		logic [7:0]       wdata;
	} mmd_rf_req_s;

	typedef struct packed {
		logic             rd;
		logic             wr;
		logic [15:0]      addr;
		logic [7:0]       wdata;
	} mmd_pm_req_s;

endpackage

// ### src/mmd_pm_classify.sv
/*
 * Program-memory address classifier: fixed location function and
 * whether the address lies in implemented flash.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module mmd_pm_classify #(
	parameter int FLASH_BYTES = 65536
) (
	// Address in
	input  wire logic [15:0]           addr_i,
	// Classification
	output mmd_pkg::mmd_pm_func_e      func_o,
	output logic                       impl_o
);

	always_comb begin
		// Widened compare, FLASH_BYTES may equal the whole space
		impl_o = {1'b0, addr_i} < 17'(FLASH_BYTES);
		if (!impl_o) begin
			func_o = mmd_pkg::PM_FN_NONE;
		end else if (addr_i < mmd_pkg::PM_RESET_VEC) begin
			func_o = mmd_pkg::PM_FN_OPTION;
		end else if (addr_i < mmd_pkg::PM_WDOG_VEC) begin
			func_o = mmd_pkg::PM_FN_RESET;
		end else if (addr_i < mmd_pkg::PM_TRAP_VEC) begin
			func_o = mmd_pkg::PM_FN_WDOG;
		end else if (addr_i < mmd_pkg::PM_IRQ_VEC) begin
			func_o = mmd_pkg::PM_FN_TRAP;
		end else if (addr_i <= mmd_pkg::PM_IRQ_LAST) begin
			func_o = mmd_pkg::PM_FN_IRQ;
		end else begin
			func_o = mmd_pkg::PM_FN_CODE;
		end
	end

endmodule

// ### src/mmd_decoder.sv
/*
 * Memory map decoder between the core and RAM, control registers and
 * flash. Requests are taken each clock, answered one cycle later.
 * A read and a write raised together count as a read only.
 * Reset clears every strobe, address, data and tag output.
 * Assumes targets return read data combinationally in the request
 * cycle and that requests are synchronous to clk_sys_i.
 * Assumes the core holds each request for one cycle; a held request
 * is simply taken again on the next edge.
 */
//
// Function
// RULE1: Separate register, program and data spaces; no data space here, a data access only raises dm_err_o
// RULE2: Register file spans 4096 byte locations
// RULE3: Source operands read, destinations written
// RULE4: F00h to FFFh decode as control registers
// RULE5: Reserved control reads undefined; avoid writes
// RULE6: RAM starts at 000h, 2KB to 4KB
// RULE7: Gap above RAM: undefined read, write ignored
// RULE8: 64KB program space, flash 16KB to 64KB
// RULE9: Program read above flash returns FFh
// RULE10: Unimplemented program write has no effect
// RULE11: Option, vectors, trap, interrupts, then code
// RULE12: General registers have no fixed role
// RULE13: 12-bit and 16-bit addresses, sized by parameters
`timescale 1ns/1ps
module mmd_decoder #(
	parameter int RAM_BYTES   = 4096,                       // [RULE13]
	parameter int FLASH_BYTES = 65536
) (
	// Clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 srst_i,
	// Core side
	input  wire mmd_pkg::mmd_rf_req_s rf_req_i,
	input  wire mmd_pkg::mmd_pm_req_s pm_req_i,
	input  wire logic                 dm_req_i,
	output logic [7:0]                rf_rdata_o,
	output logic                      rf_rvalid_o,
	output logic [7:0]                pm_rdata_o,
	output logic                      pm_rvalid_o,
	output logic                      dm_err_o,
	output mmd_pkg::mmd_pm_func_e     pm_func_o,
	// RAM target
	output logic                      ram_we_o,
	output logic                      ram_re_o,
	output logic [11:0]               ram_addr_o,
	output logic [7:0]                ram_wdata_o,
	input  wire logic [7:0]           ram_rdata_i,
	// Control register target
	output logic                      ctl_we_o,
	output logic                      ctl_re_o,
	output logic [7:0]                ctl_addr_o,
	output logic [7:0]                ctl_wdata_o,
	input  wire logic [7:0]           ctl_rdata_i,
	// Flash target
	output logic                      fl_we_o,
	output logic                      fl_re_o,
	output logic [15:0]               fl_addr_o,
	output logic [7:0]                fl_wdata_o,
	input  wire logic [7:0]           fl_rdata_i
);

	// Sizes outside the legal range are pulled to the nearest end, so
	// a bad build value cannot leave a stray window in either map
	function automatic int fit_size(
		input int v,
		input int lo,
		input int hi
	);
		if (v < lo)
			fit_size = lo;
		else if (v > hi)
			fit_size = hi;
		else
			fit_size = v;
	endfunction

	localparam int RAM_SZ   = fit_size(RAM_BYTES, mmd_pkg::RAM_MIN,
	                                   mmd_pkg::RAM_MAX);
	localparam int FLASH_SZ = fit_size(FLASH_BYTES, mmd_pkg::FLASH_MIN,
	                                   mmd_pkg::FLASH_MAX);

	function automatic mmd_pkg::mmd_rf_region_e rf_region(
		input logic [11:0] a
	);
		if (a >= mmd_pkg::RF_CTRL_BASE)                        // [RULE4]
			rf_region = mmd_pkg::RF_REG_CTRL;
		else if ({1'b0, a} < 13'(RAM_SZ))                      // [RULE6]
			rf_region = mmd_pkg::RF_REG_RAM;
		else
			rf_region = mmd_pkg::RF_REG_HOLE;                  // [RULE7]
	endfunction

	mmd_pkg::mmd_rf_region_e rf_reg;
	mmd_pkg::mmd_pm_func_e   pm_func;
	logic                    pm_impl;
	logic                    rf_hit_ram;
	logic                    rf_hit_ctl;
	logic                    rf_rd;
	logic                    rf_wr;
	logic                    pm_wr;

	// Read wins if the core raises both; never a mixed access
	always_comb begin
		rf_rd      = rf_req_i.rd;                          // [RULE3]
		rf_wr      = rf_req_i.wr & ~rf_req_i.rd;           // [RULE3]
		pm_wr      = pm_req_i.wr & ~pm_req_i.rd;
		rf_reg     = rf_region(rf_req_i.addr);             // [RULE2]
		rf_hit_ram = 1'b0;
		rf_hit_ctl = 1'b0;
		unique case (rf_reg)
			mmd_pkg::RF_REG_RAM:  rf_hit_ram = 1'b1;
			mmd_pkg::RF_REG_CTRL: rf_hit_ctl = 1'b1;
			mmd_pkg::RF_REG_HOLE: ;
			default:              ;
		endcase
	end

	mmd_pm_classify #(
		.FLASH_BYTES(FLASH_SZ)
	) mmd_pm_classify_i (
		.addr_i (pm_req_i.addr),
		.func_o (pm_func),
		.impl_o (pm_impl)
	);

	// RAM strobes; any byte is usable in any role      [RULE12]
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ram_we_o    <= 1'b0;
			ram_re_o    <= 1'b0;
			ram_addr_o  <= 12'h000;
			ram_wdata_o <= 8'h00;
		end else begin
			ram_we_o    <= rf_wr & rf_hit_ram;                    // [RULE6]
			ram_re_o    <= rf_rd & rf_hit_ram;
			ram_addr_o  <= rf_req_i.addr - mmd_pkg::RF_RAM_BASE;
			ram_wdata_o <= rf_req_i.wdata;
		end
	end

	// Control section; reserved offsets are passed on unfiltered,
	// the owning peripheral decides what they do
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctl_we_o    <= 1'b0;
			ctl_re_o    <= 1'b0;
			ctl_addr_o  <= 8'h00;
			ctl_wdata_o <= 8'h00;
		end else begin
			ctl_we_o    <= rf_wr & rf_hit_ctl;                    // [RULE4]
			ctl_re_o    <= rf_rd & rf_hit_ctl;                    // [RULE5]
			ctl_addr_o  <= rf_req_i.addr[7:0];
			ctl_wdata_o <= rf_req_i.wdata;
		end
	end

	// Register file read return; hole reads give a fixed filler
	// Read data is captured in the request cycle, so targets must
	// answer combinationally; a slow target would need a wait state
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rf_rdata_o  <= 8'h00;
			rf_rvalid_o <= 1'b0;
		end else begin
			rf_rvalid_o <= rf_rd;
			if (rf_rd) begin
				unique case (rf_reg)
					mmd_pkg::RF_REG_RAM:  rf_rdata_o <= ram_rdata_i;
					mmd_pkg::RF_REG_CTRL: rf_rdata_o <= ctl_rdata_i; // [RULE5]
					mmd_pkg::RF_REG_HOLE: rf_rdata_o <= mmd_pkg::RF_UNDEF; // [RULE7]
					default:              rf_rdata_o <= mmd_pkg::RF_UNDEF;
				endcase
			end
		end
	end

	// Flash strobes; writes past the flash are dropped here
	// Address and data follow the core every cycle, strobes qualify
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			fl_we_o    <= 1'b0;
			fl_re_o    <= 1'b0;
			fl_addr_o  <= 16'h0000;
			fl_wdata_o <= 8'h00;
		end else begin
			fl_we_o    <= pm_wr & pm_impl;                        // [RULE10]
			fl_re_o    <= pm_req_i.rd & pm_impl;                  // [RULE8]
			fl_addr_o  <= pm_req_i.addr;
			fl_wdata_o <= pm_req_i.wdata;
		end
	end

	// Program read return and fixed-location tag
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pm_rdata_o  <= 8'h00;
			pm_rvalid_o <= 1'b0;
			pm_func_o   <= mmd_pkg::PM_FN_OPTION;
		end else begin
			pm_rvalid_o <= pm_req_i.rd;
			if (pm_req_i.rd | pm_req_i.wr)
				pm_func_o <= pm_func;                              // [RULE11]
			if (pm_req_i.rd) begin
				if (pm_impl)
					pm_rdata_o <= fl_rdata_i;
				else
					pm_rdata_o <= mmd_pkg::PM_BLANK;           // [RULE9]
			end
		end
	end

	// No data-memory space exists; flag any attempt
	// One pulse per attempt, no sticky state to clear
	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			dm_err_o <= 1'b0;
		else
			dm_err_o <= dm_req_i;                                  // [RULE1]
	end

endmodule

// ### sim/mmd_monitor.sv
/* Port checker for mmd_decoder.
 * Assumes it is bound to every mmd_decoder instance. */
`timescale 1ns/1ps
module mmd_monitor #(
	parameter int RAM_BYTES   = 4096,
	parameter int FLASH_BYTES = 65536
) (
	// Clock, reset, requests
	input wire logic                  clk_sys_i,
	input wire logic                  srst_i,
	input wire mmd_pkg::mmd_rf_req_s  rf_req_i,
	input wire mmd_pkg::mmd_pm_req_s  pm_req_i,
	input wire logic                  dm_req_i,
	input wire logic [7:0]            fl_rdata_i,
	// Answers and strobes
	input wire logic [7:0]            rf_rdata_o,
	input wire logic                  rf_rvalid_o,
	input wire logic [7:0]            pm_rdata_o,
	input wire logic                  dm_err_o,
	input wire mmd_pkg::mmd_pm_func_e pm_func_o,
	input wire logic                  ram_we_o,
	input wire logic [11:0]           ram_addr_o,
	input wire logic                  ctl_re_o,
	input wire logic                  ctl_we_o,
	input wire logic [7:0]            ctl_addr_o,
	input wire logic                  fl_re_o,
	input wire logic                  fl_we_o
);
	logic [11:0] rf_a;
	logic [15:0] pm_a;
	logic [2:0]  vec;
	logic        hole;
	assign rf_a = rf_req_i.addr;
	assign pm_a = pm_req_i.addr;
	assign vec  = {1'b0, pm_a[2:1]};
	assign hole = rf_a >= RAM_BYTES && rf_a < 12'hf00;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	a_rf_answer: assert property (rf_req_i.rd |=> rf_rvalid_o)
		else $error("read not answered");
	a_ctl_decode: assert property (rf_req_i.rd && rf_a >= 12'hf00 |=>
		ctl_re_o && {4'hf, ctl_addr_o} == $past(rf_a))
		else $error("control read misrouted");
	a_ram_write: assert property (rf_req_i.wr && !rf_req_i.rd &&
		rf_a < RAM_BYTES |=> ram_we_o && ram_addr_o == $past(rf_a))
		else $error("ram write misrouted");
	a_hole_quiet: assert property (hole && rf_req_i.wr |=>
		!ram_we_o && !ctl_we_o) else $error("hole write reached target");
	a_hole_read: assert property (hole && rf_req_i.rd |=>
		rf_rdata_o == 8'h00) else $error("hole read value");
	a_pm_blank: assert property (pm_req_i.rd && pm_a >= FLASH_BYTES |=>
		pm_rdata_o == 8'hff && !fl_re_o) else $error("blank read wrong");
	a_pm_nowr: assert property (pm_req_i.wr && pm_a >= FLASH_BYTES |=>
		!fl_we_o) else $error("write above flash reached flash");
	a_pm_vector: assert property (pm_req_i.rd && pm_a < 16'h0008 |=>
		pm_func_o == $past(vec)) else $error("fixed location misclassed");
	a_pm_data: assert property (pm_req_i.rd && pm_a < FLASH_BYTES |=>
		pm_rdata_o == $past(fl_rdata_i)) else $error("flash data lost");
	a_dm_flag: assert property (dm_req_i |=> dm_err_o)
		else $error("data space access not flagged");
endmodule
bind mmd_decoder mmd_monitor #(.RAM_BYTES(RAM_BYTES),
	.FLASH_BYTES(FLASH_BYTES)) mmd_monitor_i (.clk_sys_i, .srst_i,
	.rf_req_i, .pm_req_i, .dm_req_i, .fl_rdata_i, .rf_rdata_o, .rf_rvalid_o,
	.pm_rdata_o, .dm_err_o, .pm_func_o, .ram_we_o, .ram_addr_o, .ctl_re_o,
	.ctl_we_o, .ctl_addr_o, .fl_re_o, .fl_we_o);

// ### sim/mmd_tgt_model.sv
/* Target memories seen by the decoder: RAM, control, flash.
 * Assumes read data must follow the request address combinationally. */
`timescale 1ns/1ps
module mmd_tgt_model (
	// Request addresses
	input  wire logic [11:0] rf_addr_i,
	input  wire logic [15:0] pm_addr_i,
	// Read data
	output logic [7:0]       ram_rdata_o,
	output logic [7:0]       ctl_rdata_o,
	output logic [7:0]       fl_rdata_o
);
	// Address-keyed patterns, so a wrong steer shows as wrong data
	assign ram_rdata_o = rf_addr_i[7:0] ^ 8'h5a;
	assign ctl_rdata_o = rf_addr_i[7:0] ^ 8'ha5;
	assign fl_rdata_o  = pm_addr_i[7:0] ^ pm_addr_i[15:8] ^ 8'h3c;
endmodule

// ### sim/memory_map_decoder_bench.sv
/* Self-checking bench for mmd_decoder, smallest RAM and flash.
 * Assumes mmd_monitor is bound and mmd_tgt_model supplies read data. */
`timescale 1ns/1ps
module memory_map_decoder_bench;
	logic                  clk_sys_i = 1'b0;
	logic                  srst_i    = 1'b1;
	logic                  dm_req_i  = 1'b0;
	mmd_pkg::mmd_rf_req_s  rf_req_i  = '0;
	mmd_pkg::mmd_pm_req_s  pm_req_i  = '0;
	mmd_pkg::mmd_pm_func_e pm_func_o;
	logic [7:0]  rf_rdata_o, pm_rdata_o, ram_wdata_o, ctl_wdata_o, fl_wdata_o;
	logic [7:0]  ram_rdata_i, ctl_rdata_i, fl_rdata_i, ctl_addr_o;
	logic [11:0] ram_addr_o;
	logic [15:0] fl_addr_o;
	logic        rf_rvalid_o, pm_rvalid_o, dm_err_o, ram_we_o, ram_re_o;
	logic        ctl_we_o, ctl_re_o, fl_we_o, fl_re_o;
	int          err_count  = 0;
	int          n_compared = 0;
	int          cyc        = 0;
	mmd_decoder #(.RAM_BYTES(2048), .FLASH_BYTES(16384)) mmd_decoder_i (
		.clk_sys_i, .srst_i, .rf_req_i, .pm_req_i, .dm_req_i, .rf_rdata_o,
		.rf_rvalid_o, .pm_rdata_o, .pm_rvalid_o, .dm_err_o, .pm_func_o,
		.ram_we_o, .ram_re_o, .ram_addr_o, .ram_wdata_o, .ram_rdata_i,
		.ctl_we_o, .ctl_re_o, .ctl_addr_o, .ctl_wdata_o, .ctl_rdata_i,
		.fl_we_o, .fl_re_o, .fl_addr_o, .fl_wdata_o, .fl_rdata_i);
	mmd_tgt_model mmd_tgt_model_i (.rf_addr_i(rf_req_i.addr),
		.pm_addr_i(pm_req_i.addr), .ram_rdata_o(ram_rdata_i),
		.ctl_rdata_o(ctl_rdata_i), .fl_rdata_o(fl_rdata_i));
	always #2 clk_sys_i = ~clk_sys_i;
	// Whole run needs about 44 cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One-cycle request; answer is settled one edge later
	task rf(input logic rd, wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys_i); #1 rf_req_i = '{rd, wr, a, d};
		@(posedge clk_sys_i); #1 rf_req_i = '0;
	endtask
	task pm(input logic rd, wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i); #1 pm_req_i = '{rd, wr, a, d};
		@(posedge clk_sys_i); #1 pm_req_i = '0;
	endtask
	task t_ram;
		rf(0, 1, 12'h123, 8'h3c);
		chk({ram_we_o, ram_addr_o, ram_wdata_o}, 21'h11233c);
		rf(1, 0, 12'h7ff, 8'h00);
		chk({rf_rvalid_o, ram_re_o}, 2'b11);
		chk(rf_rdata_o, 8'hff ^ 8'h5a);
		rf(1, 1, 12'h010, 8'h77);
		chk({ram_re_o, ram_we_o}, 2'b10);
		$display("t_ram done");
	endtask
	task t_ctl;
		rf(1, 0, 12'hf05, 8'h00);
		chk({ctl_re_o, ram_re_o, ctl_addr_o}, 16'h205);
		chk(rf_rdata_o, 8'h05 ^ 8'ha5);
		rf(0, 1, 12'hfff, 8'h81);
		chk({ctl_we_o, ctl_addr_o, ctl_wdata_o}, 17'h1ff81);
		rf(1, 0, 12'hf20, 8'h00);
		chk(ctl_re_o, 1'b1);
		$display("t_ctl done");
	endtask
	task t_hole;
		rf(0, 1, 12'h800, 8'h11);
		chk({ram_we_o, ctl_we_o}, 2'b00);
		rf(1, 0, 12'heff, 8'h00);
		chk({rf_rvalid_o, rf_rdata_o}, 9'h100);
		$display("t_hole done");
	endtask
	task automatic t_pm;
		logic [15:0] a [8] = '{16'h1, 16'h2, 16'h5, 16'h6, 16'h8, 16'h37,
			16'h38, 16'h3fff};
		logic [2:0] f [8] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd4, 3'd5, 3'd5};
		for (int i = 0; i < 8; i++) begin
			pm(1, 0, a[i], 8'h00);
			chk({pm_rvalid_o, fl_re_o, pm_func_o}, {2'b11, f[i]});
			chk(pm_rdata_o, a[i][7:0] ^ a[i][15:8] ^ 8'h3c);
		end
		pm(1, 0, 16'h4000, 8'h00);
		chk({pm_rvalid_o, fl_re_o, pm_func_o, pm_rdata_o}, 13'h16ff);
		pm(0, 1, 16'hffff, 8'h12);
		chk({fl_we_o, pm_rvalid_o}, 2'b00);
		pm(0, 1, 16'h0100, 8'h12);
		chk({fl_we_o, fl_addr_o, fl_wdata_o}, 25'h1010012);
		$display("t_pm done");
	endtask
	task t_dm;
		@(posedge clk_sys_i); #1 dm_req_i = 1'b1;
		@(posedge clk_sys_i); #1 dm_req_i = 1'b0;
		chk(dm_err_o, 1'b1);
		$display("t_dm done");
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		#1 srst_i = 1'b0;
		t_ram();
		t_ctl();
		t_hole();
		t_pm();
		t_dm();
		summarize();
	end
endmodule
